// ==== scr_regs.sv ====
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  // host side pins, sdio command engine clock domain
  input wire logic sd_clk_in,
  input wire scr_pkg::scr_acc_s host_acc_in,
  output logic [7:0] host_rdata_out,
  // local processor side, same clock
  input wire scr_pkg::scr_acc_s local_acc_in,
  output logic [7:0] local_rdata_out,
  // function status and bus mode
  input wire scr_pkg::scr_fn_stat_s fn_stat_in,
  input wire logic spi_mode_in,
  // suspend and resume control
  output logic suspend_req_out,
  output logic [3:0] addressed_fn_out,
  output logic resume_out,
  output logic [3:0] resume_fn_out,
  // storage area access
  input wire logic [7:0] storage_rdata_in,
  output logic storage_wr_out,
  output logic storage_rd_out,
  output logic [23:0] storage_addr_out,
  output logic [7:0] storage_wdata_out,
  output logic [15:0] blk_size_out
);

  // all state sits in one packed struct: the comb block
  // builds a full copy each cycle and the flop bank
  // registers it, so no field can keep a stale value
  // through a missing assignment
  scr_pkg::scr_state_s s_q; // registered state
  scr_pkg::scr_state_s s_d; // next state
  logic take; // host access taken this cycle
  logic [3:0] afn; // addressed function
  scr_pkg::scr_acc_s h; // synchronised host access

  // storage pointer step, shared by window reads and writes
  // the pointer wraps at the top of the 24-bit area
  // callers pass the registered pointer, so one take
  // with both strobes set still steps only once
  function automatic logic [23:0] step_ptr(input logic [23:0] p);
    logic [23:0] n; // stepped pointer
    n = p + 24'h000001;
    return n;
  endfunction

  // read one byte of the map as seen by the host
  // the local side uses the same view, so both agree
  // on reserved bits and on the spi masking of release
  function automatic logic [7:0] rd_byte(input scr_pkg::scr_state_s s,
                                         input logic [16:0] a,
                                         input logic spi);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      // common pointer, low byte first
      `SCR_A_CCIS0: r = s.ccis[7:0];
      `SCR_A_CCIS1: r = s.ccis[15:8];
      `SCR_A_CCIS2: r = s.ccis[23:16];
      // bus status: release request and transfer-active
      `SCR_A_BUS: begin
        r[`SCR_BIT_RELEASE] = s.release_req & ~spi;
        r[`SCR_BIT_ACTIVE] = s.active;
      end
      // select field with the resume data flag on top
      `SCR_A_FSEL: begin
        r[`SCR_BIT_PENDING] = s.pending;
        r[3:0] = s.fsel;
      end
      // function 1 execution and ready flags
      `SCR_A_EXEC: r[`SCR_BIT_FN1] = s.fn1_executing;
      `SCR_A_RDY: r[`SCR_BIT_FN1] = s.fn1_ready;
      // function 0 block size, low byte first
      `SCR_A_BLK0: r = s.blk[7:0];
      `SCR_A_BLK1: r = s.blk[15:8];
      // enable, support and standard code share a byte
      `SCR_A_FIC: begin
        r[`SCR_BIT_ENABLE] = s.enable;
        r[`SCR_BIT_SUPPORT] = s.support;
        r[3:0] = s.std_code;
      end
      // extended interface code
      `SCR_A_EXT: r = s.ext_code;
      // function 1 info pointer, low byte first
      `SCR_A_CIS0: r = s.cis[7:0];
      `SCR_A_CIS1: r = s.cis[15:8];
      `SCR_A_CIS2: r = s.cis[23:16];
      // storage pointer, low byte first
      `SCR_A_CSA0: r = s.csa[7:0];
      `SCR_A_CSA1: r = s.csa[15:8];
      `SCR_A_CSA2: r = s.csa[23:16];
      // window register holds the last byte moved
      `SCR_A_DAW: r = s.daw;
      // unmapped bytes read zero
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // the link clock and the host access word come from
  // outside this clock domain; both pass the same two
  // flop stages so they stay aligned, and the host must
  // hold the word steady for two cycles on each side
  // of its clock rise, which keeps every bit of the
  // word settled by the time the edge is seen
  // edge history starts low after reset, matching the
  // idle level of the link clock, so no false take
  // synchronised host view and strobe from sampled link clock edge
  assign h = s_q.p2.acc;
  assign take = s_q.p2.clk & ~s_q.clk_prev;

  // a function number carried by a live command
  // overrides the select field only while it is valid;
  // the status bit below follows whichever is chosen
  // addressed function, command number wins over select field
  assign afn = fn_stat_in.cmd_fn_valid ? fn_stat_in.cmd_fn : s_q.fsel;

  // priority inside the next state block, lowest first:
  // sampled status flags, local writes, suspend
  // completion, host writes, host reads, then the spi
  // override, which always has the last word on the
  // release request; later assignments win, so the
  // order of the sections below is part of the logic
  // and must be kept when fields are added
  // next state
  always_comb begin
    s_d = s_q;
    // two stage pin synchroniser, then edge history
    s_d.p1.clk = sd_clk_in;
    s_d.p1.acc = host_acc_in;
    s_d.p2 = s_q.p1;
    s_d.clk_prev = s_q.p2.clk;
    // single cycle strobes drop by default
    s_d.resume = 1'b0;
    s_d.st_wr = 1'b0;
    s_d.st_rd = 1'b0;
    // status inputs come from logic on this clock and
    // are registered here without extra stages
    // sample execution flag
    s_d.fn1_executing = fn_stat_in.fn1_executing;
    s_d.fn1_ready = fn_stat_in.fn1_ready;
    s_d.pending = fn_stat_in.data_pending[s_q.fsel];
    s_d.active = fn_stat_in.busy[afn];

    // the local processor owns the ccis and cis pointers, the codes
    // and the support bit; host-owned fields such as the
    // enable, the select field and the block size cannot
    // be reached from this side
    // local side writes
    if (local_acc_in.wr) begin
      unique case (local_acc_in.addr)
        `SCR_A_CCIS0: s_d.ccis[7:0] = local_acc_in.wdata;
        `SCR_A_CCIS1: s_d.ccis[15:8] = local_acc_in.wdata;
        `SCR_A_CCIS2: s_d.ccis[23:16] = local_acc_in.wdata;
        // the local side sets support and the code; the
        // enable bit in this byte belongs to the host
        `SCR_A_FIC: begin
          s_d.support = local_acc_in.wdata[`SCR_BIT_SUPPORT];
          s_d.std_code = local_acc_in.wdata[3:0];
        end
        `SCR_A_EXT: s_d.ext_code = local_acc_in.wdata;
        `SCR_A_CIS0: s_d.cis[7:0] = local_acc_in.wdata;
        `SCR_A_CIS1: s_d.cis[15:8] = local_acc_in.wdata;
        `SCR_A_CIS2: s_d.cis[23:16] = local_acc_in.wdata;
        default: s_d.ccis = s_d.ccis;
      endcase
    end
    // a local read is answered one cycle later and the
    // byte stands until the next local read
    // local reads see the same byte view
    if (local_acc_in.rd) begin
      s_d.lrd = rd_byte(s_q, local_acc_in.addr, spi_mode_in);
    end

    // completion of a suspend clears the request and
    // forces the status bit low for this cycle; a host
    // write of one in the same cycle is applied later in
    // this block and so wins over the clear
    // suspend completion clears both bits
    if (fn_stat_in.suspend_done) begin
      s_d.release_req = 1'b0;
      s_d.active = 1'b0;
    end

    // host writes act only on the cycle of the take, so a
    // word held across many cycles still lands once;
    // read-only bytes fall to the default branch
    // host side writes, taken at link clock rising edge
    if (take && h.wr) begin
      unique case (h.addr)
        `SCR_A_BUS: begin
          // host one requests suspend, wins over completion
          if (!spi_mode_in && h.wdata[`SCR_BIT_RELEASE]) begin
            s_d.release_req = 1'b1;
          end
          if (!spi_mode_in && !h.wdata[`SCR_BIT_RELEASE]) begin
            s_d.release_req = 1'b0;
          end
        end
        // the select write always lands; a resume pulse is
        // raised only if the chosen function is suspended
        `SCR_A_FSEL: begin
          s_d.fsel = h.wdata[3:0];
          if (fn_stat_in.suspended[h.wdata[3:0]]) begin
            s_d.resume = 1'b1;
            s_d.resume_fn = h.wdata[3:0];
          end
        end
        // block size bytes land one at a time; the range
        // limit is the host's duty and is not checked here
        // host writes block size
        `SCR_A_BLK0: s_d.blk[7:0] = h.wdata;
        `SCR_A_BLK1: s_d.blk[15:8] = h.wdata;
        `SCR_A_FIC: s_d.enable = h.wdata[`SCR_BIT_ENABLE];
        // a window write stores the byte and, when access
        // is enabled, strobes it into the area at the
        // pointer before the pointer steps
        `SCR_A_DAW: begin
          s_d.daw = h.wdata;
          s_d.st_wr = s_q.enable;
          s_d.st_addr = s_q.csa;
          s_d.csa = step_ptr(s_q.csa);
        end
        // host writes to read-only bytes ignored
        default: s_d.blk = s_d.blk;
      endcase
    end

    // the read byte is registered and stands until the
    // next host read; a window read also stores the
    // fetched area byte in the window register so the
    // local view matches what the host was given
    // host reads, answered one cycle after the take
    if (take && h.rd) begin
      s_d.hrd = rd_byte(s_q, h.addr, spi_mode_in);
      if (h.addr == `SCR_A_DAW) begin
        s_d.hrd = storage_rdata_in;
        s_d.daw = storage_rdata_in;
        s_d.st_rd = s_q.enable;
        s_d.st_addr = s_q.csa;
        s_d.csa = step_ptr(s_q.csa);
      end
    end

    // spi mode never keeps a pending release: the bit is
    // held low here so a mode change mid-request cannot
    // leave a stale suspend behind
    // no release request survives in SPI
    if (spi_mode_in) begin
      s_d.release_req = 1'b0;
    end
  end

  // reset clears the whole struct first and then loads
  // the fields with non-zero or named defaults; the
  // transfer-active bit starts high and follows the
  // addressed function from the first cycle after
  // release; the host should let the link clock idle
  // low across reset so the first edge seen is real
  // state register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.ccis <= `SCR_RST_CCIS;
      s_q.cis <= `SCR_RST_CIS;
      s_q.csa <= `SCR_RST_CSA;
      s_q.active <= 1'b1;
      s_q.release_req <= 1'b0;
      s_q.fsel <= `SCR_RST_FSEL;
      s_q.blk <= `SCR_RST_BLK;
      s_q.std_code <= `SCR_RST_STD;
      s_q.ext_code <= `SCR_RST_EXT;
      s_q.daw <= `SCR_RST_DAW;
    end else begin
      s_q <= s_d;
    end
  end

  // every data output below comes straight from a flop,
  // except the addressed function number, which must
  // track a command as soon as it is presented
  // storage strobes last one cycle each and are held
  // low while area access is disabled
  // outputs straight from state
  assign host_rdata_out = s_q.hrd;
  assign local_rdata_out = s_q.lrd;
  assign suspend_req_out = s_q.release_req;
  assign addressed_fn_out = afn;
  assign resume_out = s_q.resume;
  assign resume_fn_out = s_q.resume_fn;
  assign storage_wr_out = s_q.st_wr;
  assign storage_rd_out = s_q.st_rd;
  assign storage_addr_out = s_q.st_addr;
  assign storage_wdata_out = s_q.daw;
  assign blk_size_out = s_q.blk;

endmodule

// ==== scr_defs.svh ====
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
// host and local byte addresses
`define SCR_A_CCIS0 17'h00009
`define SCR_A_CCIS1 17'h0000A
`define SCR_A_CCIS2 17'h0000B
`define SCR_A_BUS 17'h0000C
`define SCR_A_FSEL 17'h0000D
`define SCR_A_EXEC 17'h0000E
`define SCR_A_RDY 17'h0000F
`define SCR_A_BLK0 17'h00010
`define SCR_A_BLK1 17'h00011
`define SCR_A_FIC 17'h00100
`define SCR_A_EXT 17'h00101
`define SCR_A_CIS0 17'h00109
`define SCR_A_CIS1 17'h0010A
`define SCR_A_CIS2 17'h0010B
`define SCR_A_CSA0 17'h0010C
`define SCR_A_CSA1 17'h0010D
`define SCR_A_CSA2 17'h0010E
`define SCR_A_DAW 17'h0010F
// field positions
`define SCR_BIT_RELEASE 1
`define SCR_BIT_ACTIVE 0
`define SCR_BIT_PENDING 7
`define SCR_BIT_FN1 1
`define SCR_BIT_ENABLE 7
`define SCR_BIT_SUPPORT 6
// reset values
`define SCR_RST_CCIS 24'h001000
`define SCR_RST_CIS 24'h002000
`define SCR_RST_CSA 24'h000000
`define SCR_RST_STD 4'h7
`define SCR_RST_EXT 8'h00
`define SCR_RST_BLK 16'h0000
`define SCR_RST_DAW 8'h00
`define SCR_RST_FSEL 4'h0
`endif

// ==== scr_pkg.sv ====
package scr_pkg;
  // one byte access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [16:0] addr;
    logic [7:0] wdata;
  } scr_acc_s;
  // status reported by the card functions
  typedef struct packed {
    logic [15:0] busy;
    logic [15:0] suspended;
    logic [15:0] data_pending;
    logic suspend_done;
    logic fn1_executing;
    logic fn1_ready;
    logic cmd_fn_valid;
    logic [3:0] cmd_fn;
  } scr_fn_stat_s;
  // one synchroniser stage of the host pins
  typedef struct packed {
    logic clk;
    scr_acc_s acc;
  } scr_pin_s;
  // whole module state
  typedef struct packed {
    scr_pin_s p1;
    scr_pin_s p2;
    logic clk_prev;
    logic [23:0] ccis;
    logic [23:0] cis;
    logic [23:0] csa;
    logic [23:0] st_addr;
    logic release_req;
    logic active;
    logic [3:0] fsel;
    logic pending;
    logic fn1_executing;
    logic fn1_ready;
    logic [15:0] blk;
    logic enable;
    logic support;
    logic [3:0] std_code;
    logic [7:0] ext_code;
    logic [7:0] daw;
    logic [7:0] hrd;
    logic [7:0] lrd;
    logic resume;
    logic [3:0] resume_fn;
    logic st_wr;
    logic st_rd;
  } scr_state_s;
endpackage

// ==== scr_regs_props.sv ====
`timescale 1ns/1ps
module scr_regs_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire scr_pkg::scr_acc_s host_acc_in,
  input wire scr_pkg::scr_fn_stat_s fn_stat_in,
  input wire logic spi_mode_in,
  input wire logic suspend_req_out,
  input wire logic [3:0] addressed_fn_out,
  input wire logic resume_out,
  input wire logic storage_rd_out,
  input wire logic storage_wr_out,
  input wire logic [15:0] blk_size_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_addr_fn;
    fn_stat_in.cmd_fn_valid |-> addressed_fn_out == fn_stat_in.cmd_fn;
  endproperty
  a_addr_fn: assert property (p_addr_fn) else $error("addressed function wrong");
  property p_done_clr;
    fn_stat_in.suspend_done && !host_acc_in.wr |=> !suspend_req_out;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("release not cleared");
  property p_req_cause;
    $rose(suspend_req_out) |-> $past(host_acc_in.wr) && !spi_mode_in;
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("release without write");
  property p_spi_keep;
    spi_mode_in && !suspend_req_out |=> !suspend_req_out;
  endproperty
  a_spi_keep: assert property (p_spi_keep) else $error("release set in spi mode");
  property p_res_pulse;
    resume_out |=> !resume_out;
  endproperty
  a_res_pulse: assert property (p_res_pulse) else $error("resume longer than one cycle");
  property p_res_cause;
    $rose(resume_out) |-> $past(host_acc_in.wr, 2);
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("resume without write");
  property p_st_pulse;
    storage_rd_out || storage_wr_out |=> !(storage_rd_out || storage_wr_out);
  endproperty
  a_st_pulse: assert property (p_st_pulse) else $error("storage strobe too long");
  property p_blk_hold;
    !host_acc_in.wr ##1 !host_acc_in.wr |=> $stable(blk_size_out);
  endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("block size moved");
endmodule

// ==== scr_host_model.sv ====
`timescale 1ns/1ps
module scr_host_model (
  input wire logic clk_in,
  output logic sd_clk_out,
  output scr_pkg::scr_acc_s acc_out
);
  // link clock idles low between frames
  initial begin
    sd_clk_out = 1'b0;
    acc_out = '0;
  end
  // one access per link clock period, held from two cycles before the rise until four cycles after the fall
  task automatic xfer(input logic wr, input logic rd, input logic [16:0] a, input logic [7:0] d);
    @(negedge clk_in);
    acc_out <= '{wr: wr, rd: rd, addr: a, wdata: d};
    repeat (2) @(negedge clk_in);
    sd_clk_out <= 1'b1;
    repeat (4) @(negedge clk_in);
    sd_clk_out <= 1'b0;
    repeat (4) @(negedge clk_in);
    // released strobes drop low; address and data lines show the inverse of the last value
    acc_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "scr_defs.svh"
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sd_clk;
  scr_pkg::scr_acc_s host_acc;
  scr_pkg::scr_acc_s local_acc = '0;
  scr_pkg::scr_fn_stat_s fn_stat = '0;
  logic spi_mode = 1'b0;
  logic [7:0] st_rdata = 8'h00;
  logic [7:0] host_rdata, local_rdata, st_wdata;
  logic sus_req, resume, st_wr, st_rd;
  logic [3:0] afn, resume_fn;
  logic [3:0] resumes = 4'h0;
  logic [3:0] strobes = 4'h0;
  logic [23:0] st_addr;
  logic [15:0] blk;
  logic [31:0] seed = 32'h9113;
  int err_count = 0;
  int samples_checked = 0;
  // reset contents, last entry unmapped
  localparam logic [16:0] RA [16] = '{17'h00009, 17'h0000A, 17'h0000B, 17'h0000C,
    17'h0000D, 17'h0000E, 17'h0000F, 17'h00010, 17'h00011, 17'h00100, 17'h00101,
    17'h00109, 17'h0010A, 17'h0010B, 17'h0010C, 17'h00200};
  localparam logic [7:0] RV [16] = '{8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  always #12.5 clk_in = ~clk_in;
  scr_host_model u_host (.clk_in(clk_in), .sd_clk_out(sd_clk), .acc_out(host_acc));
  scr_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .sd_clk_in(sd_clk),
    .host_acc_in(host_acc), .host_rdata_out(host_rdata), .local_acc_in(local_acc),
    .local_rdata_out(local_rdata), .fn_stat_in(fn_stat), .spi_mode_in(spi_mode),
    .suspend_req_out(sus_req), .addressed_fn_out(afn), .resume_out(resume),
    .resume_fn_out(resume_fn), .storage_rdata_in(st_rdata), .storage_wr_out(st_wr),
    .storage_rd_out(st_rd), .storage_addr_out(st_addr), .storage_wdata_out(st_wdata),
    .blk_size_out(blk));
  // count one-cycle pulses
  always @(negedge clk_in) begin
    if (resume === 1'b1) resumes <= resumes + 4'h1;
    if (st_rd === 1'b1 || st_wr === 1'b1) strobes <= strobes + 4'h1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hrd(input logic [16:0] a, input logic [7:0] exp);
    u_host.xfer(1'b0, 1'b1, a, 8'h00);
    check("host data", {16'h0, exp}, {16'h0, host_rdata});
    // the local side must see the same byte after the host read
    @(negedge clk_in);
    local_acc <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_in);
    local_acc <= '0;
    check("local data", {16'h0, exp}, {16'h0, local_rdata});
  endtask
  task automatic hwr(input logic [16:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, 1'b0, a, d);
  endtask
  task automatic lwr(input logic [16:0] a, input logic [7:0] d);
    @(negedge clk_in);
    local_acc <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_in);
    local_acc <= '0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, about ten times the expected run
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    rst_in <= 1'b0;
    fn_stat.busy <= 16'h0001;
    for (int i = 0; i < 16; i++) hrd(RA[i], RV[i]);
    seed = xs(seed);
    lwr(`SCR_A_CCIS0, seed[7:0]);
    hwr(`SCR_A_CCIS0, ~seed[7:0]);
    hrd(`SCR_A_CCIS0, seed[7:0]);
    lwr(`SCR_A_FIC, 8'hFF);
    lwr(`SCR_A_EXT, seed[15:8]);
    lwr(`SCR_A_CIS2, seed[23:16]);
    hrd(`SCR_A_FIC, 8'h4F);
    hrd(`SCR_A_EXT, seed[15:8]);
    hrd(`SCR_A_CIS2, seed[23:16]);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      fn_stat.fn1_executing <= seed[0];
      fn_stat.fn1_ready <= seed[1];
      hrd(`SCR_A_EXEC, {6'h00, seed[0], 1'b0});
      hrd(`SCR_A_RDY, {6'h00, seed[1], 1'b0});
    end
    // host keeps the length within 1 to 2047
    hwr(`SCR_A_BLK0, seed[7:0] | 8'h01);
    hwr(`SCR_A_BLK1, {5'h00, seed[10:8]});
    check("block size", {13'h0, seed[10:1], 1'b1}, {8'h0, blk});
    hwr(`SCR_A_BUS, 8'hFF);
    check("release", 24'h1, {23'h0, sus_req});
    hrd(`SCR_A_BUS, 8'h03);
    hwr(`SCR_A_BUS, 8'h00);
    check("cancel", 24'h0, {23'h0, sus_req});
    hwr(`SCR_A_BUS, 8'h02);
    fn_stat.suspend_done <= 1'b1;
    fn_stat.busy <= 16'h0000;
    @(negedge clk_in);
    fn_stat.suspend_done <= 1'b0;
    hrd(`SCR_A_BUS, 8'h00);
    spi_mode <= 1'b1;
    hwr(`SCR_A_BUS, 8'h02);
    hrd(`SCR_A_BUS, 8'h00);
    spi_mode <= 1'b0;
    fn_stat.suspended <= 16'h0008;
    fn_stat.data_pending <= 16'h0008;
    hwr(`SCR_A_FSEL, 8'hF3);
    check("resume", 24'h13, {16'h0, resumes, resume_fn});
    hrd(`SCR_A_FSEL, 8'h83);
    fn_stat.cmd_fn_valid <= 1'b1;
    fn_stat.cmd_fn <= 4'h5;
    @(negedge clk_in);
    check("addressed", 24'h5, {20'h0, afn});
    fn_stat.cmd_fn_valid <= 1'b0;
    // disabled window access moves the pointer but raises no strobe
    u_host.xfer(1'b0, 1'b1, `SCR_A_DAW, 8'h00);
    check("strobes off", 24'h0, {20'h0, strobes});
    hwr(`SCR_A_FIC, 8'h80);
    hrd(`SCR_A_FIC, 8'hCF);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      st_rdata <= seed[7:0];
      hrd(`SCR_A_DAW, seed[7:0]);
      hwr(`SCR_A_DAW, seed[15:8]);
      check("window", {16'h0, seed[15:8]}, {16'h0, st_wdata});
      check("window addr", 24'(2 * i + 2), st_addr);
    end
    check("strobes", 24'h6, {20'h0, strobes});
    hrd(`SCR_A_CSA0, 8'h07);
    wrap_up();
  end
endmodule
bind scr_regs scr_regs_props u_props (.clk_in(clk_in), .rst_in(rst_in),
  .host_acc_in(host_acc_in), .fn_stat_in(fn_stat_in), .spi_mode_in(spi_mode_in),
  .suspend_req_out(suspend_req_out), .addressed_fn_out(addressed_fn_out),
  .resume_out(resume_out), .storage_rd_out(storage_rd_out),
  .storage_wr_out(storage_wr_out), .blk_size_out(blk_size_out));
